//--- hdl/sbs_evt_sync.sv
`timescale 1ns/10ps
`default_nettype none
module sbs_evt_sync import sbs_pkg::*; (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic [7:0] i_tgl,
  output logic [7:0] o_pulse
);

  logic [7:0] meta_r;
  logic [7:0] sync_r;
  logic [7:0] last_r;
  logic [2:0] arm_r;

  localparam int pulse_lat = SBS_SYNC_STAGES - 1;

  // Toggle crossing: each far-side event flips one line, so no event is
  // lost however short it was on the far side
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      meta_r <= 8'h00;
      sync_r <= 8'h00;
      last_r <= 8'h00;
    end else begin
      meta_r <= i_tgl;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  // Detector stays blind until all stages hold the far level, so a line that
  // idles high across reset gives no false event; a flip in the very first
  // cycle after reset is taken as the line's level
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      arm_r <= 3'h0;
    end else begin
      arm_r <= {arm_r[1:0], 1'b1};
    end
  end

  // One-cycle pulse per flip, taken only from the settled stages
  assign o_pulse = (sync_r ^ last_r) & {8{arm_r[2]}};

  sync_lat_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (arm_r[0] && (i_tgl[0] != $past(i_tgl[0]))) |-> ##pulse_lat o_pulse[0])
    else $error("event toggle not turned into a pulse two cycles later");

endmodule
`default_nettype wire

//--- hdl/sbs_pkg.sv
package sbs_pkg;

  // Register byte offsets inside the APB window
  localparam logic [7:0] SBS_OFS_STATUS = 8'h00;
  localparam logic [7:0] SBS_OFS_CLR = 8'h04;
  localparam logic [7:0] SBS_OFS_SET = 8'h08;
  localparam logic [7:0] SBS_OFS_INV = 8'h0c;

  // Field positions in the status word
  localparam int SBS_BIT_IN_ALL_FULL = 15;
  localparam int SBS_BIT_IN_OVF = 14;
  localparam int SBS_LSB_IN_SLOT = 8;
  localparam int SBS_BIT_OUT_ALL_EMPTY = 7;
  localparam int SBS_BIT_OUT_UDF = 6;
  localparam int SBS_LSB_OUT_SLOT = 0;

  // Number of byte buffers on each side
  localparam int SBS_NBUF = 4;

  // Reset values of the flags
  localparam logic [3:0] SBS_RST_IN_SLOT = 4'h0;
  localparam logic [3:0] SBS_RST_OUT_SLOT = 4'hf;
  localparam logic SBS_RST_OVF = 1'b0;
  localparam logic SBS_RST_UDF = 1'b0;

  // Number of flops in the event synchroniser chain
  localparam int SBS_SYNC_STAGES = 3;

  // Alias operations selected by the address
  typedef enum logic [1:0] {
    SBS_OP_WRITE,
    SBS_OP_CLR,
    SBS_OP_SET,
    SBS_OP_INV
  } sbs_op_t;

  // APB request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } sbs_apb_req_t;

  // APB answer to the master
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } sbs_apb_rsp_t;

endpackage

//--- hdl/sbs_status.sv
// Contract
// - Input-all-full reads 1 only while every input buffer holds data.
// - A master write to a full input buffer sets overflow; only software clears it.
// - Each input slot flag is 1 while its buffer holds unread data and 0 after a read.
// - Output-all-empty reads 1 only while every output buffer is empty.
// - A master read of an empty output buffer sets underflow until software clears it.
// - Reserved status bits are written as zero and read as zero here.
// - The alias at +0x4 clears each implemented bit written with a one. Here only overflow and underflow do.
// - The alias at +0x8 sets each implemented bit written with a one. Here only overflow and underflow do.
// - The alias at +0xC inverts each implemented bit written with a one. Here only overflow and underflow do.
// - Each output slot flag is 1 while empty and 0 from a software write until taken.
//
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module sbs_status import sbs_pkg::*; (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire sbs_apb_req_t i_apb,
  output sbs_apb_rsp_t o_apb,
  input wire logic [3:0] i_ext_wr_tgl,
  input wire logic [3:0] i_ext_rd_tgl,
  input wire logic [3:0] i_sw_in_rd,
  input wire logic [3:0] i_sw_out_wr,
  output logic [3:0] o_in_slot_full,
  output logic [3:0] o_out_slot_empty,
  output logic o_input_all_full,
  output logic o_output_all_empty
);

  sbs_apb_rsp_t rsp_r;
  logic [3:0] in_full_r;
  logic [3:0] in_full_nxt;
  logic [3:0] out_empty_r;
  logic [3:0] out_empty_nxt;
  logic ovf_r;
  logic ovf_nxt;
  logic udf_r;
  logic udf_nxt;
  logic all_full_r;
  logic all_empty_r;
  logic [7:0] evt_pulse;
  logic [3:0] ext_wr_p;
  logic [3:0] ext_rd_p;
  logic acc;
  logic wr_en;
  logic map_hit;
  sbs_op_t op;
  logic ovf_hw;
  logic udf_hw;

  // Function to apply a software write or alias write to one R/W bit
  function automatic logic sw_bit(input logic cur, input sbs_op_t o, input logic d);
    logic r;
    r = cur;
    case (o)
      SBS_OP_WRITE: r = d;
      SBS_OP_CLR: r = cur & ~d;
      SBS_OP_SET: r = cur | d;
      SBS_OP_INV: r = cur ^ d;
      default: r = cur;
    endcase
    return r;
  endfunction

  // Function to assemble the status word; reserved bits stay zero
  function automatic logic [31:0] status_word(input logic afull, input logic ovf,
      input logic [3:0] ifull, input logic aempty, input logic udf, input logic [3:0] oempty);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[SBS_BIT_IN_ALL_FULL] = afull;
    w[SBS_BIT_IN_OVF] = ovf;
    w[SBS_LSB_IN_SLOT +: SBS_NBUF] = ifull;
    w[SBS_BIT_OUT_ALL_EMPTY] = aempty;
    w[SBS_BIT_OUT_UDF] = udf;
    w[SBS_LSB_OUT_SLOT +: SBS_NBUF] = oempty;
    return w;
  endfunction

  // Far-side buffer events cross into the bus clock domain
  sbs_evt_sync u_evt_sync (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .i_tgl({i_ext_rd_tgl, i_ext_wr_tgl}),
    .o_pulse(evt_pulse)
  );

  assign ext_wr_p = evt_pulse[3:0];
  assign ext_rd_p = evt_pulse[7:4];

  // Address decode and the one edge at which a write lands
  assign acc = i_apb.psel & i_apb.penable;
  assign wr_en = acc & i_apb.pwrite & rsp_r.pready;
  assign map_hit = (i_apb.paddr == SBS_OFS_STATUS) || (i_apb.paddr == SBS_OFS_CLR) ||
                   (i_apb.paddr == SBS_OFS_SET) || (i_apb.paddr == SBS_OFS_INV);

  always_comb begin
    case (i_apb.paddr)
      SBS_OFS_CLR: op = SBS_OP_CLR;
      SBS_OFS_SET: op = SBS_OP_SET;
      SBS_OFS_INV: op = SBS_OP_INV;
      default: op = SBS_OP_WRITE;
    endcase
  end

  // Hardware error events: a write into a full slot, a read of an empty one
  assign ovf_hw = |(ext_wr_p & in_full_r);
  assign udf_hw = |(ext_rd_p & out_empty_r);

  // Next values of the flags; hardware set always beats a software clear
  always_comb begin
    in_full_nxt = (in_full_r & ~i_sw_in_rd) | ext_wr_p;
    out_empty_nxt = (out_empty_r & ~i_sw_out_wr) | ext_rd_p;
    ovf_nxt = ovf_r;
    udf_nxt = udf_r;
    if (wr_en && map_hit) begin
      ovf_nxt = sw_bit(ovf_r, op, i_apb.pwdata[SBS_BIT_IN_OVF]);
      udf_nxt = sw_bit(udf_r, op, i_apb.pwdata[SBS_BIT_OUT_UDF]);
    end
    if (ovf_hw) begin
      ovf_nxt = 1'b1;
    end
    if (udf_hw) begin
      udf_nxt = 1'b1;
    end
  end

  // Slot flags follow buffer traffic only; software cannot force them
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      in_full_r <= SBS_RST_IN_SLOT;
      out_empty_r <= SBS_RST_OUT_SLOT;
    end else begin
      in_full_r <= in_full_nxt;
      out_empty_r <= out_empty_nxt;
    end
  end

  // Sticky error flags
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ovf_r <= SBS_RST_OVF;
      udf_r <= SBS_RST_UDF;
    end else begin
      ovf_r <= ovf_nxt;
      udf_r <= udf_nxt;
    end
  end

  // Aggregates held in flops built from the next slot values, so they
  // never lag the slot flags by a cycle
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      all_full_r <= &SBS_RST_IN_SLOT;
      all_empty_r <= &SBS_RST_OUT_SLOT;
    end else begin
      all_full_r <= &in_full_nxt;
      all_empty_r <= &out_empty_nxt;
    end
  end

  // APB answer: one wait state, so read data comes from a flop at a known edge
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rsp_r <= '0;
    end else begin
      rsp_r.pready <= acc & ~rsp_r.pready;
      rsp_r.pslverr <= acc & ~rsp_r.pready & ~map_hit;
      if (acc && !rsp_r.pready && !i_apb.pwrite && i_apb.paddr == SBS_OFS_STATUS) begin
        rsp_r.prdata <= status_word(all_full_r, ovf_r, in_full_r,
                                    all_empty_r, udf_r, out_empty_r);
      end else begin
        rsp_r.prdata <= 32'h0000_0000; // Aliases and holes read as zero
      end
    end
  end

  assign o_apb = rsp_r;
  assign o_in_slot_full = in_full_r;
  assign o_out_slot_empty = out_empty_r;
  assign o_input_all_full = all_full_r;
  assign o_output_all_empty = all_empty_r;

  // Software write into one alias, bit for bit
  sequence alias_wr(logic [7:0] ofs, int b);
    wr_en && i_apb.paddr == ofs && i_apb.pwdata[b];
  endsequence

  all_full_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    ##1 (o_input_all_full == (o_in_slot_full == 4'hf)))
    else $error("input all-full does not match the slot flags");

  ovf_set_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    ovf_hw |=> ovf_r ##1 (ovf_r || $past(wr_en)))
    else $error("overflow not set or lost without a software write");

  slot_rd_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    |(i_sw_in_rd & ~ext_wr_p) |=> ((in_full_r & $past(i_sw_in_rd & ~ext_wr_p)) == 4'h0))
    else $error("input slot still full after software read");

  all_empty_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    $changed(out_empty_r) |-> (o_output_all_empty == (o_out_slot_empty == 4'hf)))
    else $error("output all-empty does not match the slot flags");

  udf_hold_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (udf_r && !wr_en) |=> udf_r)
    else $error("underflow dropped without a software write");

  rsvd_zero_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    rsp_r.pready |-> (rsp_r.prdata[13:12] == 2'b00))
    else $error("reserved status bits read non-zero");

  clr_alias_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (alias_wr(SBS_OFS_CLR, SBS_BIT_IN_OVF) and (!ovf_hw)) |=> !ovf_r)
    else $error("clear alias did not clear overflow");

  set_alias_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    alias_wr(SBS_OFS_SET, SBS_BIT_OUT_UDF) |=> udf_r ##1 (udf_r || $past(wr_en)))
    else $error("set alias did not set underflow");

  inv_alias_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (alias_wr(SBS_OFS_INV, SBS_BIT_IN_OVF) and (!ovf_hw)) |=> (ovf_r != $past(ovf_r)))
    else $error("invert alias did not flip overflow");

  slot_wr_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    |(i_sw_out_wr & ~ext_rd_p) |=> ((out_empty_r & $past(i_sw_out_wr & ~ext_rd_p)) == 4'h0))
    else $error("output slot still empty after software write");

  apb_wait_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (acc && !rsp_r.pready) |=> rsp_r.pready ##1 !rsp_r.pready)
    else $error("APB answer not given after exactly one wait state");

  // Each rule once more, seen through the outputs that software and the far side use
  all_full_set_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    ((&(in_full_r | ext_wr_p)) && !(|i_sw_in_rd)) |=> o_input_all_full)
    else $error("input all-full not raised with every slot full");

  all_full_drop_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (|(i_sw_in_rd & ~ext_wr_p)) |=> !o_input_all_full)
    else $error("input all-full kept after a slot was read");

  ovf_quiet_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (!ovf_r && !ovf_hw && !wr_en) |=> !ovf_r)
    else $error("overflow rose with no event and no write");

  ovf_rise_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (ext_wr_p[0] && o_in_slot_full[0]) |=> ovf_r)
    else $error("write into full slot 0 did not set overflow");

  in_fill_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (|ext_wr_p) |=> ((o_in_slot_full & $past(ext_wr_p)) == $past(ext_wr_p)))
    else $error("input slot not full after a far-side write");

  in_hold_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (!(|ext_wr_p) && !(|i_sw_in_rd)) |=> $stable(o_in_slot_full))
    else $error("input slot flags moved with no buffer traffic");

  all_empty_set_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    ((&(out_empty_r | ext_rd_p)) && !(|i_sw_out_wr)) |=> o_output_all_empty)
    else $error("output all-empty not raised with every slot empty");

  all_empty_drop_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (|(i_sw_out_wr & ~ext_rd_p)) |=> !o_output_all_empty)
    else $error("output all-empty kept after a slot was written");

  udf_rise_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (|(ext_rd_p & o_out_slot_empty)) |=> udf_r)
    else $error("read of an empty slot did not set underflow");

  udf_quiet_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (!udf_r && !udf_hw && !wr_en) |=> !udf_r)
    else $error("underflow rose with no event and no write");

  rsvd_high_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    rsp_r.pready |-> (rsp_r.prdata[31:16] == 16'h0000 && rsp_r.prdata[5:4] == 2'b00))
    else $error("upper or low reserved status bits read non-zero");

  clr_keep_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (wr_en && i_apb.paddr == SBS_OFS_CLR && !i_apb.pwdata[SBS_BIT_IN_OVF] && !ovf_hw)
      |=> (ovf_r == $past(ovf_r)))
    else $error("clear alias changed overflow written with zero");

  clr_udf_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (alias_wr(SBS_OFS_CLR, SBS_BIT_OUT_UDF) and (!udf_hw)) |=> !udf_r)
    else $error("clear alias did not clear underflow");

  set_ovf_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    alias_wr(SBS_OFS_SET, SBS_BIT_IN_OVF) |=> ovf_r)
    else $error("set alias did not set overflow");

  inv_udf_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (alias_wr(SBS_OFS_INV, SBS_BIT_OUT_UDF) and (!udf_hw)) |=> (udf_r != $past(udf_r)))
    else $error("invert alias did not flip underflow");

  out_take_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (|ext_rd_p) |=> ((o_out_slot_empty & $past(ext_rd_p)) == $past(ext_rd_p)))
    else $error("output slot not empty after a far-side read");

  out_hold_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (!(|ext_rd_p) && !(|i_sw_out_wr)) |=> $stable(o_out_slot_empty))
    else $error("output slot flags moved with no buffer traffic");

endmodule
`default_nettype wire

//--- tb/sbs_far_master.sv
`timescale 1ns/10ps
`default_nettype none
// Far parallel master: each request pulse flips that buffer's event toggle
module sbs_far_master (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic [3:0] i_wr_req,
  input wire logic [3:0] i_rd_req,
  output logic [3:0] o_wr_tgl,
  output logic [3:0] o_rd_tgl
);
  // Toggles, not pulses, so an access survives the crossing whatever its width
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_wr_tgl <= 4'h0;
      o_rd_tgl <= 4'h0;
    end else begin
      o_wr_tgl <= o_wr_tgl ^ i_wr_req;
      o_rd_tgl <= o_rd_tgl ^ i_rd_req;
    end
  end
endmodule
`default_nettype wire

//--- tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench import sbs_pkg::*;;
  logic clk, nrst, se;
  sbs_apb_req_t req;
  sbs_apb_rsp_t rsp;
  logic [3:0] wr_req, rd_req, sw_rd, sw_wr, wtg, rtg, ifl, oem;
  logic afull, aempty;
  logic [31:0] rd;
  int errors, n_compared, cyc, i;

  sbs_far_master far (.i_core_clk(clk), .i_nrst(nrst), .i_wr_req(wr_req),
    .i_rd_req(rd_req), .o_wr_tgl(wtg), .o_rd_tgl(rtg));
  sbs_status DUT (.i_core_clk(clk), .i_nrst(nrst), .i_apb(req), .o_apb(rsp),
    .i_ext_wr_tgl(wtg), .i_ext_rd_tgl(rtg), .i_sw_in_rd(sw_rd), .i_sw_out_wr(sw_wr),
    .o_in_slot_full(ifl), .o_out_slot_empty(oem), .o_input_all_full(afull),
    .o_output_all_empty(aempty));

  // 125 MHz bus clock
  always #4 clk = ~clk;

  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      finish_test;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One APB transfer; request held until pready is sampled high, only the hang guard ends a wait
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= wr;
    req.paddr <= a;
    req.pwdata <= d;
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    se = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  // Status word through the bus, and the same flags on the level outputs
  task automatic st(input logic [31:0] exp);
    apb(1'b0, SBS_OFS_STATUS, 32'h0);
    chk(rd, exp);
    chk({16'h0, afull, 3'h0, ifl, aempty, 3'h0, oem}, exp & 32'h8f8f);
  endtask

  // Event on buffer n: 0 far write, 1 far read, 2 software read, 3 software write
  task automatic ev(input int k, input int n);
    @(posedge clk);
    case (k)
      0: wr_req[n] <= 1'b1;
      1: rd_req[n] <= 1'b1;
      2: sw_rd[n] <= 1'b1;
      default: sw_wr[n] <= 1'b1;
    endcase
    @(posedge clk);
    {wr_req, rd_req, sw_rd, sw_wr} <= 16'h0;
    repeat (5) @(posedge clk);
  endtask

  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    req = '0;
    {wr_req, rd_req, sw_rd, sw_wr} = 16'h0;
    errors = 0;
    n_compared = 0;
    cyc = 0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    st(32'h008f);
    for (i = 0; i < 4; i++) ev(0, i);
    st(32'h8f8f);
    ev(0, 0);
    st(32'hcf8f);
    ev(2, 0);
    st(32'h4e8f);
    $display("test input side done");
    apb(1'b1, SBS_OFS_CLR, 32'h4040);
    st(32'h0e8f);
    apb(1'b1, SBS_OFS_SET, 32'h4040);
    st(32'h4ecf);
    apb(1'b1, SBS_OFS_INV, 32'h4040);
    st(32'h0e8f);
    apb(1'b0, SBS_OFS_CLR, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, SBS_OFS_STATUS, 32'h4000);
    st(32'h4e8f);
    apb(1'b1, 8'h10, 32'hffff);
    chk({31'h0, se}, 32'h1);
    st(32'h4e8f);
    $display("test aliases done");
    ev(3, 1);
    st(32'h4e0d);
    ev(1, 1);
    st(32'h4e8f);
    ev(1, 2);
    st(32'h4ecf);
    $display("test output side done");
    finish_test;
  end
endmodule
`default_nettype wire
